/* rtl/lpd_pkg.sv */
// Shared constants and types for the four-lane 7:1 pixel link.
package lpd_pkg;
    localparam int LANES = 4;
    localparam int BITS_PER_LANE = 7;
    localparam int WORD_W = 28;
    localparam int COLOR_W = 8;
    localparam int PIX_W = 24;
    localparam int FIFO_DEPTH = 8;
    localparam int CLK_SYS_MHZ = 125;
    localparam int CLK_PERIOD_NS = 8;
    // One link clock cycle spans this many system clock cycles, one bit slot each.
    localparam int LINK_DIV = BITS_PER_LANE;
    localparam int LINK_PERIOD_NS = LINK_DIV * CLK_PERIOD_NS;
    localparam logic [2:0] POS_FIRST = 3'h0;
    localparam logic [2:0] POS_LAST = 3'h6;
    // The forwarded clock is high for bit positions below this one.
    localparam logic [2:0] POS_CLK_LOW = 3'h4;
    localparam logic [2:0] LOCK_LAST = 3'h3;
    localparam int SLOT_SPARE = 23;
    localparam int SLOT_HSYNC = 24;
    localparam int SLOT_VSYNC = 25;
    localparam int SLOT_ENABLE = 26;
    localparam logic [WORD_W-1:0] IDLE_WORD = 28'h0000000;
    // Serial slot carried by lane l at bit position n, indexed l*7+n.
    localparam int SLOT_MAP [LANES*BITS_PER_LANE] = '{
        0, 1, 2, 3, 4, 6, 7,
        8, 9, 12, 13, 14, 15, 18,
        19, 20, 21, 22, 24, 25, 26,
        27, 5, 10, 11, 16, 17, 23};
    // Slot of colour bit i, ordered red 0..7, green 0..7, blue 0..7.
    localparam int COLOR_MSB3 [PIX_W] = '{
        0, 1, 2, 3, 4, 6, 27, 5,
        7, 8, 9, 12, 13, 14, 10, 11,
        15, 18, 19, 20, 21, 22, 16, 17};
    localparam int COLOR_LSB3 [PIX_W] = '{
        27, 5, 0, 1, 2, 3, 4, 6,
        10, 11, 7, 8, 9, 12, 13, 14,
        16, 17, 15, 18, 19, 20, 21, 22};
    typedef enum logic [2:0] {
        LPD_HUNT = 3'b001,
        LPD_TRACK = 3'b010,
        LPD_LOCKED = 3'b100
    } lpd_rx_state_e;
endpackage

/* rtl/lpd_link_if.sv */
// Serial link carrier between the transmitting and receiving ends.
`timescale 1ns/1ps
interface lpd_link_if;
    logic link_clk;
    logic [3:0] serial_lane;
    modport tx (output link_clk, output serial_lane);
    modport rx (input link_clk, input serial_lane);
endinterface

/* rtl/lpd_rx.sv */
// Word FIFO and the receiving end of the 7:1 pixel link.
//
// Overview of operation
// - Seven bits per lane per link cycle.
// - Transmitter launches bit n at nT/7.
// - Receiver samples bit n mid-slot.
// - All strobes derived from forwarded clock.
// - Serial slot k appears on output k.
// - Lane three carries slots 27,5,10,11,16,17,23.
// - Lane two carries slots 19-22,24-26.
// - Slots 24-26 sync and enable; 23 spare.
// - MSB option: lane three carries bits 6,7.
// - MSB option: red 0-4,6; green 7; blue 15.
// - 18 bpp sinks drop lane three bits.
// - Receiver gives 28 parallel bits per cycle.
// - LSB option: lane three carries bits 0,1.
`timescale 1ns/1ps
module lpd_fifo #(
    parameter int WIDTH = lpd_pkg::WORD_W,
    parameter int DEPTH = lpd_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys, // System clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] in_data, // Word to store.
    input wire logic in_valid, // Source offers a word.
    output logic in_ready, // Room for one more word.
    output logic [WIDTH-1:0] out_data, // Oldest stored word.
    output logic out_valid, // A word is stored.
    input wire logic out_ready // Sink takes the oldest word.
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("FIFO depth must be a power of two of at least two");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg, wr_ptr_next;
    logic [PW-1:0] rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0] count_reg, count_next;
    logic ready_reg, ready_next;
    logic valid_reg, valid_next;
    logic push, pop;

    always_comb begin
        push = in_valid & ready_reg;
        pop = valid_reg & out_ready;
        wr_ptr_next = push ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
        rd_ptr_next = pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
        count_next = count_reg;
        if (push && !pop) begin
            count_next = CW'(count_reg + 1'b1);
        end else if (pop && !push) begin
            count_next = CW'(count_reg - 1'b1);
        end
        ready_next = (count_next != CW'(DEPTH));
        valid_next = (count_next != '0);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            ready_reg <= 1'b0;
            valid_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            ready_reg <= ready_next;
            valid_reg <= valid_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    assign in_ready = ready_reg;
    assign out_valid = valid_reg;
    assign out_data = mem[rd_ptr_reg];
endmodule // lpd_fifo

module lpd_rx (
    input wire logic clk_sys, // System clock.
    input wire logic resetn, // Asynchronous reset, active low.
    lpd_link_if.rx link, // Serial lanes and forwarded clock.
    input wire logic msb_on_lane3, // Colour option: high for MSBs on lane three.
    output logic [27:0] parallel_out_bit, // Received word, bit k from slot k.
    output logic word_valid, // One-cycle pulse with each new word.
    output logic [7:0] red, // Red component.
    output logic [7:0] green, // Green component.
    output logic [7:0] blue, // Blue component.
    output logic hsync, // Horizontal sync.
    output logic vsync, // Vertical sync.
    output logic display_enable, // Display enable.
    output logic spare_bit, // Spare general-purpose bit.
    output logic locked, // Link framing is locked.
    output logic frame_error // One-cycle pulse on a framing fault.
);
    localparam int NCAP = lpd_pkg::LANES * lpd_pkg::BITS_PER_LANE;

    lpd_pkg::lpd_rx_state_e state_reg, state_next;
    logic [2:0] pos_reg, pos_next;
    logic [2:0] cnt_reg, cnt_next;
    logic clk_prev_reg;
    logic [NCAP-1:0] cap_reg, cap_next;
    logic [27:0] word_reg, word_next;
    logic [7:0] red_reg, red_next;
    logic [7:0] green_reg, green_next;
    logic [7:0] blue_reg, blue_next;
    logic hsync_reg, vsync_reg, enable_reg, spare_reg;
    logic valid_reg, err_reg, locked_reg;
    logic rise, capture_en, done, err;

    // Bit positions count from the rising edge of the forwarded clock only.
    assign rise = link.link_clk & ~clk_prev_reg;

    always_comb begin
        state_next = state_reg;
        pos_next = pos_reg;
        cnt_next = cnt_reg;
        capture_en = 1'b0;
        done = 1'b0;
        err = 1'b0;
        unique case (state_reg)
            lpd_pkg::LPD_HUNT: begin
                if (rise) begin
                    state_next = lpd_pkg::LPD_TRACK;
                    pos_next = lpd_pkg::POS_FIRST;
                    cnt_next = '0;
                    capture_en = 1'b1;
                end
            end
            lpd_pkg::LPD_TRACK, lpd_pkg::LPD_LOCKED: begin
                if (rise) begin
                    pos_next = lpd_pkg::POS_FIRST;
                    capture_en = 1'b1;
                    // An edge before seven bits arrived breaks the 7:1 framing.
                    if (pos_reg != lpd_pkg::POS_LAST) begin
                        err = 1'b1;
                        state_next = lpd_pkg::LPD_TRACK;
                        cnt_next = '0;
                    end
                end else if (pos_reg == lpd_pkg::POS_LAST) begin
                    err = 1'b1;
                    state_next = lpd_pkg::LPD_HUNT;
                    cnt_next = '0;
                end else begin
                    pos_next = 3'(pos_reg + 1'b1);
                    capture_en = 1'b1;
                    if (pos_next == lpd_pkg::POS_LAST) begin
                        done = 1'b1;
                        if (state_reg == lpd_pkg::LPD_TRACK) begin
                            if (cnt_reg == lpd_pkg::LOCK_LAST) begin
                                state_next = lpd_pkg::LPD_LOCKED;
                            end else begin
                                cnt_next = 3'(cnt_reg + 1'b1);
                            end
                        end
                    end
                end
            end
        endcase
    end

    // Each clock edge is the centre strobe of the slot launched at the edge before.
    generate
        for (genvar i = 0; i < NCAP; i++) begin : g_cap
            always_comb begin
                if (capture_en && pos_next == 3'(i % lpd_pkg::BITS_PER_LANE)) begin
                    cap_next[i] = link.serial_lane[i / lpd_pkg::BITS_PER_LANE];
                end else begin
                    cap_next[i] = cap_reg[i];
                end
            end
        end
    endgenerate

    always_comb begin
        word_next = word_reg;
        red_next = red_reg;
        green_next = green_reg;
        blue_next = blue_reg;
        if (done) begin
            for (int i = 0; i < NCAP; i++) begin
                word_next[lpd_pkg::SLOT_MAP[i]] = cap_next[i];
            end
            for (int i = 0; i < lpd_pkg::COLOR_W; i++) begin
                if (msb_on_lane3) begin
                    red_next[i] = word_next[lpd_pkg::COLOR_MSB3[i]];
                    green_next[i] = word_next[lpd_pkg::COLOR_MSB3[i + 8]];
                    blue_next[i] = word_next[lpd_pkg::COLOR_MSB3[i + 16]];
                end else begin
                    red_next[i] = word_next[lpd_pkg::COLOR_LSB3[i]];
                    green_next[i] = word_next[lpd_pkg::COLOR_LSB3[i + 8]];
                    blue_next[i] = word_next[lpd_pkg::COLOR_LSB3[i + 16]];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= lpd_pkg::LPD_HUNT;
            pos_reg <= lpd_pkg::POS_LAST;
            cnt_reg <= '0;
            clk_prev_reg <= 1'b1;
            cap_reg <= '0;
            word_reg <= lpd_pkg::IDLE_WORD;
            red_reg <= '0;
            green_reg <= '0;
            blue_reg <= '0;
            hsync_reg <= 1'b0;
            vsync_reg <= 1'b0;
            enable_reg <= 1'b0;
            spare_reg <= 1'b0;
            valid_reg <= 1'b0;
            err_reg <= 1'b0;
            locked_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pos_reg <= pos_next;
            cnt_reg <= cnt_next;
            clk_prev_reg <= link.link_clk;
            cap_reg <= cap_next;
            word_reg <= word_next;
            red_reg <= red_next;
            green_reg <= green_next;
            blue_reg <= blue_next;
            hsync_reg <= word_next[lpd_pkg::SLOT_HSYNC];
            vsync_reg <= word_next[lpd_pkg::SLOT_VSYNC];
            enable_reg <= word_next[lpd_pkg::SLOT_ENABLE];
            spare_reg <= word_next[lpd_pkg::SLOT_SPARE];
            valid_reg <= done;
            err_reg <= err;
            locked_reg <= (state_next == lpd_pkg::LPD_LOCKED);
        end
    end

    assign parallel_out_bit = word_reg;
    assign word_valid = valid_reg;
    assign red = red_reg;
    assign green = green_reg;
    assign blue = blue_reg;
    assign hsync = hsync_reg;
    assign vsync = vsync_reg;
    assign display_enable = enable_reg;
    assign spare_bit = spare_reg;
    assign locked = locked_reg;
    assign frame_error = err_reg;
endmodule // lpd_rx

/* rtl/lpd_tx.sv */
// Transmitting end of the 7:1 pixel link with its input word FIFO.
`timescale 1ns/1ps
module lpd_tx #(
    parameter int FIFO_DEPTH = lpd_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys, // System clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic msb_on_lane3, // Colour option: high for MSBs on lane three.
    input wire logic [7:0] red, // Red component.
    input wire logic [7:0] green, // Green component.
    input wire logic [7:0] blue, // Blue component.
    input wire logic hsync, // Horizontal sync.
    input wire logic vsync, // Vertical sync.
    input wire logic display_enable, // Display enable.
    input wire logic spare_bit, // Spare general-purpose bit.
    input wire logic in_valid, // A pixel is offered.
    output logic in_ready, // The pixel is taken when valid.
    lpd_link_if.tx link // Serial lanes and forwarded clock.
);
    logic [27:0] word_in;
    logic [23:0] pix;
    logic [27:0] f_data;
    logic f_valid, f_pop;
    logic [2:0] pos_reg, pos_next;
    logic [27:0] word_reg, word_next;
    logic [3:0] lane_reg, lane_next;
    logic lclk_reg, lclk_next;

    always_comb begin
        pix = {blue, green, red};
        word_in = lpd_pkg::IDLE_WORD;
        for (int i = 0; i < lpd_pkg::PIX_W; i++) begin
            if (msb_on_lane3) begin
                word_in[lpd_pkg::COLOR_MSB3[i]] = pix[i];
            end else begin
                word_in[lpd_pkg::COLOR_LSB3[i]] = pix[i];
            end
        end
        word_in[lpd_pkg::SLOT_HSYNC] = hsync;
        word_in[lpd_pkg::SLOT_VSYNC] = vsync;
        word_in[lpd_pkg::SLOT_ENABLE] = display_enable;
        word_in[lpd_pkg::SLOT_SPARE] = spare_bit;
    end

    lpd_fifo #(
        .WIDTH(lpd_pkg::WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_data(word_in),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(f_pop)
    );

    // A new word is fetched at every seventh slot; an empty FIFO sends the idle word.
    always_comb begin
        f_pop = 1'b0;
        word_next = word_reg;
        if (pos_reg == lpd_pkg::POS_LAST) begin
            pos_next = lpd_pkg::POS_FIRST;
            f_pop = f_valid;
            word_next = f_valid ? f_data : lpd_pkg::IDLE_WORD;
        end else begin
            pos_next = 3'(pos_reg + 1'b1);
        end
        lclk_next = (pos_next < lpd_pkg::POS_CLK_LOW);
    end

    generate
        for (genvar l = 0; l < lpd_pkg::LANES; l++) begin : g_lane
            always_comb begin
                lane_next[l] =
                    word_next[lpd_pkg::SLOT_MAP[l * lpd_pkg::BITS_PER_LANE + int'(pos_next)]];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pos_reg <= lpd_pkg::POS_LAST;
            word_reg <= lpd_pkg::IDLE_WORD;
            lane_reg <= '0;
            lclk_reg <= 1'b0;
        end else begin
            pos_reg <= pos_next;
            word_reg <= word_next;
            lane_reg <= lane_next;
            lclk_reg <= lclk_next;
        end
    end

    assign link.link_clk = lclk_reg;
    assign link.serial_lane = lane_reg;
endmodule // lpd_tx

/* test/lpd_link_properties.sv */
// Concurrent checks on the serial link and the receiver's word outputs.
`timescale 1ns/1ps
module lpd_link_properties (
    input wire logic clk_sys, // System clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic link_clk, // Forwarded link clock.
    input wire logic [3:0] serial_lane, // Serial data lanes.
    input wire logic [27:0] parallel_out_bit, // Received word.
    input wire logic word_valid, // New word pulse.
    input wire logic hsync, // Horizontal sync.
    input wire logic vsync, // Vertical sync.
    input wire logic display_enable, // Display enable.
    input wire logic spare_bit, // Spare bit.
    input wire logic locked // Framing locked.
);
    logic [27:0] hist_reg;
    logic [27:0] hist_next;
    logic [27:0] exp_word;
    // Nibble j of the history holds the lanes sampled j+1 cycles ago.
    always_comb begin
        hist_next = {hist_reg[23:0], serial_lane};
        exp_word = '0;
        for (int l = 0; l < 4; l++) begin
            for (int n = 0; n < 7; n++) begin
                exp_word[lpd_pkg::SLOT_MAP[l*7+n]] = hist_reg[4*(6-n)+l];
            end
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hist_reg <= '0;
        end else begin
            hist_reg <= hist_next;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    sequence s_high_run;
        link_clk[*4];
    endsequence
    sequence s_low_run;
        !link_clk[*3];
    endsequence
    a_clk_high_four: assert property (
        $rose(link_clk) |-> s_high_run ##1 s_low_run ##1 link_clk)
        else $error("link clock frame is not seven cycles");
    a_clk_low_three: assert property (
        $fell(link_clk) |-> s_low_run ##1 $rose(link_clk))
        else $error("link clock low phase is not three cycles");
    a_idle_after_reset: assert property (
        $rose(resetn) |-> !link_clk ##1 (link_clk && serial_lane == 4'h0)[*4]
            ##1 (!link_clk && serial_lane == 4'h0)[*3])
        else $error("first frame after reset is not the idle word");
    a_slot_to_output: assert property (
        word_valid |-> parallel_out_bit == exp_word)
        else $error("received word does not match lane bits");
    a_lane3_rows: assert property (
        word_valid |-> {parallel_out_bit[27], parallel_out_bit[5], parallel_out_bit[10],
            parallel_out_bit[11], parallel_out_bit[16], parallel_out_bit[17],
            parallel_out_bit[23]} == {hist_reg[27], hist_reg[23], hist_reg[19],
            hist_reg[15], hist_reg[11], hist_reg[7], hist_reg[3]})
        else $error("lane three slots misplaced");
    a_lane2_rows: assert property (
        word_valid |-> parallel_out_bit[26:24] == {hist_reg[2], hist_reg[6], hist_reg[10]}
            && parallel_out_bit[22:19] == {hist_reg[14], hist_reg[18], hist_reg[22],
            hist_reg[26]})
        else $error("lane two slots misplaced");
    a_sync_slots: assert property (
        word_valid |-> {spare_bit, display_enable, vsync, hsync}
            == {parallel_out_bit[23], parallel_out_bit[26:24]})
        else $error("sync or spare output not from its slot");
    a_word_spacing: assert property (
        word_valid |=> !word_valid[*6])
        else $error("words closer than one link cycle");
    a_hold_between: assert property (
        !word_valid |-> $stable(parallel_out_bit))
        else $error("word output changed without a new word");
    a_word_each_frame: assert property (
        $rose(link_clk) && locked |-> word_valid)
        else $error("locked receiver skipped a word");
endmodule // lpd_link_properties

/* test/test_lvds_pixel_deserializer_map.sv */
// Self-checking bench joining the transmitting and receiving ends.
`timescale 1ns/1ps
module test_lvds_pixel_deserializer_map;
    typedef struct {logic [27:0] word; logic [27:0] pix;} lpd_note_s;
    logic clk_sys, resetn, msb, tx_valid, tx_ready, bad_err;
    logic [27:0] pix, rx_word;
    logic [7:0] rx_red, rx_green, rx_blue;
    logic rx_valid, rx_hs, rx_vs, rx_en, rx_sp, rx_locked, rx_err;
    int mismatches = 0;
    int check_count = 0;
    int refused = 0;
    int fe_count = 0;
    lpd_note_s exp_q[$];
    lpd_note_s exp_w;
    lpd_link_if link ();
    lpd_link_if bad_link ();
    lpd_tx #(.FIFO_DEPTH(lpd_pkg::FIFO_DEPTH)) u_lpd_tx (.clk_sys(clk_sys), .resetn(resetn),
        .msb_on_lane3(msb), .red(pix[7:0]), .green(pix[15:8]), .blue(pix[23:16]),
        .hsync(pix[24]), .vsync(pix[25]), .display_enable(pix[26]), .spare_bit(pix[27]),
        .in_valid(tx_valid), .in_ready(tx_ready), .link(link));
    lpd_rx u_lpd_rx (.clk_sys(clk_sys), .resetn(resetn), .link(link), .msb_on_lane3(msb),
        .parallel_out_bit(rx_word), .word_valid(rx_valid), .red(rx_red), .green(rx_green),
        .blue(rx_blue), .hsync(rx_hs), .vsync(rx_vs), .display_enable(rx_en),
        .spare_bit(rx_sp), .locked(rx_locked), .frame_error(rx_err));
    lpd_rx u_lpd_rx_fault (.clk_sys(clk_sys), .resetn(resetn), .link(bad_link),
        .msb_on_lane3(msb), .parallel_out_bit(), .word_valid(), .red(), .green(), .blue(),
        .hsync(), .vsync(), .display_enable(), .spare_bit(), .locked(),
        .frame_error(bad_err));
    lpd_link_properties u_lpd_link_properties (.clk_sys(clk_sys), .resetn(resetn),
        .link_clk(link.link_clk), .serial_lane(link.serial_lane),
        .parallel_out_bit(rx_word), .word_valid(rx_valid), .hsync(rx_hs), .vsync(rx_vs),
        .display_enable(rx_en), .spare_bit(rx_sp), .locked(rx_locked));
    always #4 clk_sys = ~clk_sys;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic timeout();
        check(32'h0, 32'h1);
        give_verdict();
    endtask
    // Pixel layout: red, green, blue, then hsync, vsync, enable and spare at the top.
    function automatic logic [27:0] map_word(input logic [27:0] v, input logic opt);
        logic [27:0] w;
        w = '0;
        for (int i = 0; i < 24; i++) begin
            w[opt ? lpd_pkg::COLOR_MSB3[i] : lpd_pkg::COLOR_LSB3[i]] = v[i];
        end
        w[26:23] = v[27:24] == 4'h0 ? 4'h0 : {v[26:24], v[27]};
        return w;
    endfunction
    task automatic push(input logic [27:0] v);
        int n;
        tx_valid <= 1'b1;
        pix <= v;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (tx_ready !== 1'b1 && n < 200);
        if (n >= 200) timeout();
        exp_q.push_back('{map_word(v, msb), v});
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 3000) timeout();
        repeat (2) @(posedge clk_sys);
        check({31'h0, tx_ready}, 32'h1);
    endtask
    // Lanes of the faulty link change every cycle so stale data never looks valid.
    task automatic bad_frame(input int len);
        for (int j = 0; j < len; j++) begin
            bad_link.link_clk <= (j < 4);
            bad_link.serial_lane <= 4'($urandom);
            @(posedge clk_sys);
        end
    endtask
    always @(posedge clk_sys) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b0) refused++;
        if (bad_err === 1'b1) fe_count++;
        if (rx_err === 1'b1) check(32'h1, 32'h0);
        if (resetn === 1'b1 && rx_valid === 1'b1 && rx_word !== 28'h0) begin
            if (exp_q.size() == 0) begin
                check({4'h0, rx_word}, 32'h0);
            end else begin
                exp_w = exp_q.pop_front();
                check({4'h0, rx_word}, {4'h0, exp_w.word});
                check({8'h0, rx_blue, rx_green, rx_red}, {8'h0, exp_w.pix[23:0]});
                check({28'h0, rx_sp, rx_en, rx_vs, rx_hs}, {28'h0, exp_w.pix[27:24]});
                // With lane-three LSBs, the upper six bits per colour come from lanes 0..2.
                if (msb === 1'b0) begin
                    check({14'h0, rx_blue[7:2], rx_green[7:2], rx_red[7:2]}, {14'h0,
                        exp_w.word[22:18], exp_w.word[15], exp_w.word[14:12], exp_w.word[9:7],
                        exp_w.word[6], exp_w.word[4:0]});
                end
            end
        end
    end
    initial begin
        logic [27:0] v;
        int n;
        clk_sys = 1'b0;
        resetn = 1'b0;
        msb = 1'b1;
        tx_valid = 1'b0;
        pix = '0;
        bad_link.link_clk = 1'b0;
        bad_link.serial_lane = 4'h0;
        void'($urandom(38));
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        n = 0;
        while (rx_locked !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        check({31'h0, rx_locked}, 32'h1);
        if (rx_locked !== 1'b1) timeout();
        for (int opt = 1; opt >= 0; opt--) begin
            msb <= opt[0];
            for (int i = 0; i < 28; i++) push(28'h1 << i);
            for (int i = 0; i < 20; i++) begin
                v = 28'($urandom);
                if (v == 28'h0) v = 28'h1;
                push(v);
            end
            tx_valid <= 1'b0;
            drain();
        end
        check({31'h0, refused != 0}, 32'h1);
        repeat (3) bad_frame(7);
        check(fe_count, 0);
        bad_frame(6);
        repeat (2) bad_frame(7);
        check(fe_count, 1);
        bad_frame(9);
        repeat (2) bad_frame(7);
        check(fe_count, 2);
        give_verdict();
    end
endmodule // test_lvds_pixel_deserializer_map
